// file: hdl/csl_top.sv
// Functional notes
// - Clearing link enable halts link machine
// - Clearing calibration enable halts calibration machine
// - Setting calibration enable resumes calibration
// - Setting link enable restarts link machine
// - Link states follow receiver sync
// - Trigger low then high starts calibration
// - Single-channel mode samples both clock edges
// - Lower lanes full rate, upper half
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module csl_top
   import csl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic sync_se_n,
   input wire logic sync_ts_n,
   input wire logic analog_high_supply_good,
   output logic core_low_supply_en,
   output logic dual_edge_sample,
   output logic [15:0] lane_enable,
   output logic upper_lane_half_rate,
   output logic [4:0] link_mode_select,
   output logic [4:0] multiframe_length_minus_one,
   output logic send_cgs,
   output logic lane_valid,
   output logic cal_busy,
   input wire logic [7:0] ovr_sample,
   output logic overrange_flag
);
   // ==========================================
   // Register bus
   logic [31:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt, ovr_r, ovr_nxt;
   logic [31:0] dat_r, dat_nxt, byte_mask, rd_word, stat_word, cfg_wmask;
   logic ack_r, ack_nxt, req, wr_go;
   logic trig_prev_r, trig_prev_nxt, trig_rise;
   csl_link_t link_state;
   csl_cal_t cal_state;
   logic cal_done, sync_q;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign byte_mask[8*gi +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   assign req = wb_cyc_i & wb_stb_i;
   // Write lands on the same edge the master sees ack
   assign wr_go = req & wb_we_i & ack_r;


   // Settings are frozen while their state machine runs
   always_comb begin
      cfg_wmask = byte_mask & 32'h00000000;
      if (!ctrl_r[CTRL_LINK_EN_BIT]) cfg_wmask = cfg_wmask | (byte_mask & CFG_LINK_MASK);
      if (!ctrl_r[CTRL_CAL_EN_BIT]) cfg_wmask = cfg_wmask | (byte_mask & CFG_CAL_MASK);
   end

   always_comb begin
      stat_word = 32'h00000000;
      stat_word[STAT_LINK_LSB +: 2] = link_state;
      stat_word[STAT_CAL_LSB +: 2] = cal_state;
      stat_word[STAT_CAL_DONE_BIT] = cal_done;
      stat_word[STAT_CORE_EN_BIT] = core_low_supply_en;
      stat_word[STAT_SYNC_BIT] = sync_q;
      stat_word[STAT_OVR_BIT] = overrange_flag;
   end

   always_comb begin
      unique case (wb_adr_i)
         ADDR_CTRL: rd_word = ctrl_r;
         ADDR_CFG: rd_word = cfg_r;
         ADDR_OVR: rd_word = ovr_r;
         ADDR_STAT: rd_word = stat_word;
         default: rd_word = 32'h00000000;
      endcase
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      cfg_nxt = cfg_r;
      ovr_nxt = ovr_r;
      dat_nxt = dat_r;
      ack_nxt = req & ~ack_r;
      trig_prev_nxt = ctrl_r[CTRL_TRIG_BIT];
      if (req && !ack_r) dat_nxt = rd_word;
      if (wr_go) begin
         unique case (wb_adr_i)
            ADDR_CTRL: begin
               ctrl_nxt = (ctrl_r & ~(byte_mask & CTRL_MASK))
                        | (wb_dat_i & byte_mask & CTRL_MASK);
            end
            ADDR_CFG: cfg_nxt = (cfg_r & ~cfg_wmask) | (wb_dat_i & cfg_wmask);
            ADDR_OVR: begin
               ovr_nxt = (ovr_r & ~(byte_mask & OVR_MASK))
                       | (wb_dat_i & byte_mask & OVR_MASK);
            end
            default: ;
         endcase
      end
   end


   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RST;
         cfg_r <= CFG_RST;
         ovr_r <= OVR_RST;
         dat_r <= 32'h00000000;
         ack_r <= 1'b0;
         trig_prev_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         cfg_r <= cfg_nxt;
         ovr_r <= ovr_nxt;
         dat_r <= dat_nxt;
         ack_r <= ack_nxt;
         trig_prev_r <= trig_prev_nxt;
      end
   end


   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   // Only a 0 then 1 sequence on the trigger bit starts a run
   assign trig_rise = ctrl_r[CTRL_TRIG_BIT] & ~trig_prev_r;

   // ==========================================
   // Link and calibration machines
   logic sync_pin_n;
   // Source switch only happens while the link is halted, so no glitch reaches the link
   assign sync_pin_n = cfg_r[CFG_SYNC_SEL_BIT] ? sync_se_n : sync_ts_n;


   csl_link u_link (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .link_en(ctrl_r[CTRL_LINK_EN_BIT]),
      .km1(cfg_r[CFG_KM1_LSB +: 5]),
      .sync_raw_n(sync_pin_n),
      .state(link_state),
      .sync_n(sync_q),
      .send_cgs(send_cgs),
      .lane_valid(lane_valid)
   );


   csl_cal u_cal (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cal_en(ctrl_r[CTRL_CAL_EN_BIT]),
      .start(trig_rise),
      .background(cfg_r[CFG_BGCAL_BIT]),
      .state(cal_state),
      .busy(cal_busy),
      .done(cal_done)
   );

   // ==========================================
   // Supply sequencing, lanes, sampling, overrange
   logic pg1_r, pg2_r, pg3_r, pg_r, pg_nxt;
   logic [15:0] lane_r, lane_nxt;
   logic half_r, half_nxt, des_r, des_nxt, ovf_r, ovf_nxt;
   logic [4:0] mode_r, mode_nxt, km1_r, km1_nxt;

   always_comb begin
      pg_nxt = (pg2_r == pg3_r) ? pg3_r : pg_r;
      lane_nxt = 16'h0000;
      if (ctrl_r[CTRL_LINK_EN_BIT]) begin
         lane_nxt = {{8{cfg_r[CFG_LANE16_BIT]}}, 8'hFF};
      end
      half_nxt = cfg_r[CFG_LANE16_BIT];
      // Single-channel reuses the same clock by sampling both edges
      des_nxt = cfg_r[CFG_SINGLE_BIT];
      mode_nxt = cfg_r[CFG_MODE_LSB +: 5];
      km1_nxt = cfg_r[CFG_KM1_LSB +: 5];
      ovf_nxt = ctrl_r[CTRL_OVERRANGE_ENABLE_BIT] && (ovr_sample > ovr_r[7:0]);
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pg1_r <= 1'b0;
         pg2_r <= 1'b0;
         pg3_r <= 1'b0;
         pg_r <= 1'b0;
         lane_r <= 16'h0000;
         half_r <= 1'b0;
         des_r <= 1'b0;
         mode_r <= 5'h00;
         km1_r <= 5'h00;
         ovf_r <= 1'b0;
      end else begin
         pg1_r <= analog_high_supply_good;
         pg2_r <= pg1_r;
         pg3_r <= pg2_r;
         pg_r <= pg_nxt;
         lane_r <= lane_nxt;
         half_r <= half_nxt;
         des_r <= des_nxt;
         mode_r <= mode_nxt;
         km1_r <= km1_nxt;
         ovf_r <= ovf_nxt;
      end
   end


   // Drops with the filtered good flag, no extra delay stage
   assign core_low_supply_en = pg_r;
   assign lane_enable = lane_r;
   assign upper_lane_half_rate = half_r;
   assign dual_edge_sample = des_r;
   assign link_mode_select = mode_r;
   assign multiframe_length_minus_one = km1_r;
   assign overrange_flag = ovf_r;

   // ==========================================
   // Checks

   ack_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      req && !ack_r |=> ack_r ##1 !ack_r) else $error("ack not one cycle");
   mode_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_r[CTRL_LINK_EN_BIT] |=> $stable(cfg_r[CFG_MODE_LSB +: 5]))
      else $error("mode changed while link runs");
   calopt_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_r[CTRL_CAL_EN_BIT] |=> $stable(cfg_r[CFG_BGCAL_BIT])) else $error("cal option changed");
   cal_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      trig_rise && (cal_state == CAL_IDLE) && ctrl_r[CTRL_CAL_EN_BIT] |=> cal_busy)
      else $error("trigger did not start cal");
   core_on_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(core_low_supply_en) |-> $past(pg3_r) && $past(pg2_r))
      else $error("core supply on without good");
   core_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      pg_r && !pg2_r && !pg3_r |=> !core_low_supply_en) else $error("core supply kept on");
   des_mode_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cfg_r[CFG_SINGLE_BIT] |=> dual_edge_sample) else $error("dual edge not set");
   lane_rate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_r[CTRL_LINK_EN_BIT] |=> lane_enable[7:0] == 8'hFF) else $error("low lanes off");
   link_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(ctrl_r[CTRL_LINK_EN_BIT]) |-> ##[1:2] link_state == LINK_CGS)
      else $error("link did not restart");

   // Fields that must stay frozen while their machines run, then resume, lane, sampling, overrange, trigger and bus checks
   km1_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_r[CTRL_LINK_EN_BIT] |=> $stable(cfg_r[CFG_KM1_LSB +: 5]))
      else $error("multiframe length changed while link runs");

   sync_sel_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_r[CTRL_LINK_EN_BIT] |=> $stable(cfg_r[CFG_SYNC_SEL_BIT]))
      else $error("sync source changed while link runs");

   ofs_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_r[CTRL_CAL_EN_BIT] |=> $stable(cfg_r[CFG_OFSCAL_BIT]))
      else $error("offset option changed");

   cal_resume_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(ctrl_r[CTRL_CAL_EN_BIT]) |=> cal_state != CAL_HALT)
      else $error("cal did not resume");

   lane_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ctrl_r[CTRL_LINK_EN_BIT] |=> lane_enable == 16'h0000)
      else $error("lanes on while link halted");

   upper_lane_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      ctrl_r[CTRL_LINK_EN_BIT] && cfg_r[CFG_LANE16_BIT] |=> lane_enable[15:8] == 8'hFF)
      else $error("upper lanes off");

   half_rate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> upper_lane_half_rate == $past(cfg_r[CFG_LANE16_BIT]))
      else $error("upper lane rate wrong");

   des_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !cfg_r[CFG_SINGLE_BIT] |=> !dual_edge_sample)
      else $error("dual edge set in dual channel mode");

   ovr_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ctrl_r[CTRL_OVERRANGE_ENABLE_BIT] |=> !overrange_flag)
      else $error("overrange flag while disabled");

   trig_once_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      trig_rise |=> !trig_rise)
      else $error("trigger edge repeated");

   mode_copy_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> link_mode_select == $past(cfg_r[CFG_MODE_LSB +: 5]))
      else $error("link mode output wrong");

   rd_data_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      req && !ack_r |=> wb_dat_o == $past(rd_word))
      else $error("read data not latched");
endmodule : csl_top
`default_nettype wire

// file: hdl/csl_pkg.sv
package csl_pkg;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int CAL_TIME_NS = 1000;
   localparam int CAL_CYCLES = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ILAS_MULTIFRAMES = 4;
   // ==========================================
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_OVR = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0C;
   // ==========================================
   // Control fields
   localparam int CTRL_LINK_EN_BIT = 0;
   localparam int CTRL_CAL_EN_BIT = 1;
   localparam int CTRL_TRIG_BIT = 2;
   localparam int CTRL_OVERRANGE_ENABLE_BIT = 3;
   localparam logic [31:0] CTRL_MASK = 32'h0000000F;
   localparam logic [31:0] CTRL_RST = 32'h00000003;
   // ==========================================
   // Configuration fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_KM1_LSB = 8;
   localparam int CFG_SYNC_SEL_BIT = 16;
   localparam int CFG_BGCAL_BIT = 17;
   localparam int CFG_OFSCAL_BIT = 18;
   localparam int CFG_SINGLE_BIT = 19;
   localparam int CFG_LANE16_BIT = 20;
   localparam logic [31:0] CFG_LINK_MASK = 32'h00191F1F;
   localparam logic [31:0] CFG_CAL_MASK = 32'h00060000;
   localparam logic [31:0] CFG_RST = 32'h00011F00;
   // ==========================================
   // Overrange and status fields
   localparam logic [31:0] OVR_MASK = 32'h000000FF;
   localparam logic [31:0] OVR_RST = 32'h000000F0;
   localparam int STAT_LINK_LSB = 0;
   localparam int STAT_CAL_LSB = 2;
   localparam int STAT_CAL_DONE_BIT = 4;
   localparam int STAT_CORE_EN_BIT = 5;
   localparam int STAT_SYNC_BIT = 6;
   localparam int STAT_OVR_BIT = 7;
   // ==========================================
   // State types
   typedef enum logic [1:0] {LINK_HALT, LINK_CGS, LINK_ILAS, LINK_DATA} csl_link_t;
   typedef enum logic [1:0] {CAL_HALT, CAL_IDLE, CAL_RUN, CAL_BG} csl_cal_t;
endpackage : csl_pkg

// file: hdl/csl_link.sv
`timescale 1ns/1ps
`default_nettype none
module csl_link
   import csl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic link_en,
   input wire logic [4:0] km1,
   input wire logic sync_raw_n,
   output csl_link_t state,
   output logic sync_n,
   output logic send_cgs,
   output logic lane_valid
);
   logic s1_r, s2_r, s3_r, sync_r, sync_nxt;
   csl_link_t state_r, state_nxt;
   logic [8:0] cnt_r, cnt_nxt;
   localparam logic [8:0] ILAS_MF = 9'(ILAS_MULTIFRAMES);

   always_comb begin
      sync_nxt = (s2_r == s3_r) ? s3_r : sync_r;
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         LINK_HALT: if (link_en) state_nxt = LINK_CGS;
         LINK_CGS: if (sync_r) begin
            state_nxt = LINK_ILAS;
            cnt_nxt = ILAS_MF * {4'h0, km1} + ILAS_MF - 9'h001;
         end
         LINK_ILAS: begin
            cnt_nxt = cnt_r - 9'h001;
            if (!sync_r) state_nxt = LINK_CGS;
            else if (cnt_r == 9'h000) state_nxt = LINK_DATA;
         end
         LINK_DATA: if (!sync_r) state_nxt = LINK_CGS;
      endcase
      if (!link_en) state_nxt = LINK_HALT;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         // Start at the requesting level so no false ILAS follows reset
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         sync_r <= 1'b0;
         state_r <= LINK_HALT;
         cnt_r <= 9'h000;
      end else begin
         s1_r <= sync_raw_n;
         s2_r <= s1_r;
         s3_r <= s2_r;
         sync_r <= sync_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign state = state_r;
   assign sync_n = sync_r;
   assign send_cgs = (state_r == LINK_CGS);
   assign lane_valid = (state_r == LINK_DATA);

   link_halt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !link_en |=> state_r == LINK_HALT) else $error("link not halted");
   sync_loss_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      link_en && state_r == LINK_DATA && !sync_r |=> state_r == LINK_CGS)
      else $error("sync loss ignored");
   ilas_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      state_r == LINK_CGS && !sync_r && link_en |=> state_r == LINK_CGS)
      else $error("left cgs without sync");
endmodule : csl_link
`default_nettype wire

// file: hdl/csl_cal.sv
`timescale 1ns/1ps
`default_nettype none
module csl_cal
   import csl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cal_en,
   input wire logic start,
   input wire logic background,
   output csl_cal_t state,
   output logic busy,
   output logic done
);
   localparam logic [8:0] RUN_LAST = 9'(CAL_CYCLES - 1);
   csl_cal_t state_r, state_nxt;
   logic [8:0] cnt_r, cnt_nxt;
   logic done_r, done_nxt;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      done_nxt = done_r;
      unique case (state_r)
         CAL_HALT: if (cal_en) state_nxt = background ? CAL_BG : CAL_IDLE;
         CAL_IDLE, CAL_BG: if (start) begin
            state_nxt = CAL_RUN;
            cnt_nxt = 9'h000;
            done_nxt = 1'b0;
         end
         CAL_RUN: begin
            cnt_nxt = cnt_r + 9'h001;
            if (cnt_r == RUN_LAST) begin
               state_nxt = background ? CAL_BG : CAL_IDLE;
               done_nxt = 1'b1;
            end
         end
      endcase
      if (!cal_en) state_nxt = CAL_HALT;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_r <= CAL_HALT;
         cnt_r <= 9'h000;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign state = state_r;
   assign busy = (state_r == CAL_RUN);
   assign done = done_r;

   cal_halt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !cal_en |=> state_r == CAL_HALT) else $error("cal not halted");
   cal_length_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(busy) && cal_en |-> busy [*8]) else $error("cal run too short");
endmodule : csl_cal
`default_nettype wire

// file: bench/csl_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Link receiver: holds sync low until it has seen code groups for a while
module csl_rx_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic send_cgs,
   input wire logic use_ts,
   input wire logic slow,
   input wire logic resync,
   output logic sync_se_n,
   output logic sync_ts_n
);
   logic sync_r;
   int cnt_r;
   always_ff @(posedge ref_clk) begin
      if (!reset_n || resync) begin
         sync_r <= 1'b0;
         cnt_r <= 0;
      end else if (send_cgs && !sync_r) begin
         cnt_r <= cnt_r + 1;
         if (cnt_r >= (slow ? 30 : 3)) sync_r <= 1'b1;
      end
   end
   // Unused source stays low so a wrong source choice keeps the link in CGS
   assign sync_se_n = use_ts ? 1'b0 : sync_r;
   assign sync_ts_n = use_ts ? sync_r : 1'b0;
endmodule : csl_rx_model
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import csl_pkg::*;
   logic ref_clk, reset_n, cyc, stb, we, good, use_ts, slow, resync, ack, core_en;
   logic des, half, cgs, lv, busy, oflag, se_n, ts_n;
   logic [7:0] adr, ovr, thr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, dat_o, cfg;
   logic [15:0] lanes;
   logic [4:0] mode_o, km1_o;
   int failures = 0, tests_run = 0, seed = 47, n;
   csl_top csl_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .sync_se_n(se_n), .sync_ts_n(ts_n), .analog_high_supply_good(good),
      .core_low_supply_en(core_en), .dual_edge_sample(des), .lane_enable(lanes),
      .upper_lane_half_rate(half), .link_mode_select(mode_o),
      .multiframe_length_minus_one(km1_o), .send_cgs(cgs), .lane_valid(lv),
      .cal_busy(busy), .ovr_sample(ovr), .overrange_flag(oflag));
   csl_rx_model csl_rx_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .send_cgs(cgs),
      .use_ts(use_ts), .slow(slow), .resync(resync), .sync_se_n(se_n), .sync_ts_n(ts_n));
   // ==========
   // Helpers
   task report_and_stop;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask : chk
   // Request held until ack is sampled high, then released for one cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
         input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
      do begin @(posedge ref_clk); k++; end while (ack !== 1'b1 && k < 20);
      rdat = dat_o;
      chk("ack", 32'h1, 32'(ack));
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge ref_clk);
   endtask : wb
   function automatic logic sig(input int i);
      case (i)
         0: return cgs;
         1: return lv;
         2: return busy;
         default: return core_en;
      endcase
   endfunction : sig
   task automatic wait_on(input int i, input logic v, input int m);
      n = 0;
      while (sig(i) !== v && n < m) begin @(posedge ref_clk); n++; end
      chk("wait", 32'(v), 32'(sig(i)));
   endtask : wait_on
   function automatic logic [31:0] exp_lanes(input logic l16);
      return {16'h0, l16 ? 8'hFF : 8'h00, 8'hFF};
   endfunction : exp_lanes
   // ==========
   // Clock, watchdog, tests
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      failures++;
      report_and_stop;
   end
   initial begin
      reset_n = 0; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0; good = 0;
      use_ts = 0; slow = 0; resync = 0; ovr = 0; cfg = CFG_RST;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      chk("core_off", 32'h0, 32'(core_en));
      wb(1'b0, ADDR_CTRL, 4'hF, 32'h0); chk("ctrl_rst", CTRL_RST, rdat);
      wb(1'b0, ADDR_CFG, 4'hF, 32'h0); chk("cfg_rst", CFG_RST, rdat);
      wb(1'b0, ADDR_OVR, 4'hF, 32'h0); chk("ovr_rst", OVR_RST, rdat);
      wb(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, 8'h10, 4'hF, 32'h0); chk("unmapped", 32'h0, rdat);
      good <= 1'b1;
      wait_on(3, 1'b1, 8);
      $display("test reset done");
      for (int p = 0; p < 2; p++) begin
         wb(1'b1, ADDR_CFG, 4'hF, $random(seed));
         wb(1'b0, ADDR_CFG, 4'hF, 32'h0); chk("cfg_lock", cfg, rdat);
         wb(1'b1, ADDR_CTRL, 4'hF, 32'h2);
         repeat (2) @(posedge ref_clk);
         chk("halt", 32'h0, 32'({cgs, lv, lanes}));
         wb(1'b1, ADDR_CTRL, 4'hF, 32'h0);
         wb(1'b0, ADDR_STAT, 4'hF, 32'h0); chk("cal_halt", 32'h0, rdat & 32'hF);
         cfg = $random(seed) & (CFG_LINK_MASK | CFG_CAL_MASK);
         cfg[CFG_SYNC_SEL_BIT] = p[0];
         wb(1'b1, ADDR_CFG, 4'hF, cfg | 32'hFFE0E0E0);
         wb(1'b0, ADDR_CFG, 4'hF, 32'h0); chk("cfg", cfg, rdat);
         chk("mode", 32'(cfg[4:0]), 32'(mode_o));
         chk("km1", 32'(cfg[12:8]), 32'(km1_o));
         wb(1'b1, ADDR_CTRL, 4'hF, 32'h2);
         wb(1'b0, ADDR_STAT, 4'hF, 32'h0);
         chk("cal_on", cfg[17] ? 32'h3 : 32'h1, (rdat >> 2) & 32'h3);
         thr = 8'($random(seed)) & 8'hFE;
         wb(1'b1, ADDR_OVR, 4'h1, {24'hA5C3E1, thr});
         wb(1'b0, ADDR_OVR, 4'hF, 32'h0); chk("thr", 32'(thr), rdat);
         wb(1'b1, ADDR_CTRL, 4'hF, 32'hA);
         ovr <= thr + 8'h01;
         repeat (2) @(posedge ref_clk);
         chk("ovr_hi", 32'h1, 32'(oflag));
         ovr <= thr;
         repeat (2) @(posedge ref_clk);
         chk("ovr_lo", 32'h0, 32'(oflag));
         use_ts <= !cfg[CFG_SYNC_SEL_BIT];
         slow <= 1'($random(seed));
         wb(1'b1, ADDR_CTRL, 4'hF, 32'hB);
         wait_on(0, 1'b1, 8);
         chk("lanes", exp_lanes(cfg[20]), 32'(lanes));
         chk("half", 32'(cfg[20]), 32'(half));
         chk("des", 32'(cfg[19]), 32'(des));
         wait_on(0, 1'b0, 80);
         wait_on(1, 1'b1, 200);
         chk("ilas", 32'(4 * (cfg[12:8] + 1)), 32'(n));
         resync <= 1'b1;
         wait_on(0, 1'b1, 12);
         resync <= 1'b0;
         wait_on(1, 1'b1, 300);
         wb(1'b1, ADDR_CTRL, 4'hF, 32'hB);
         wb(1'b1, ADDR_CTRL, 4'hF, 32'hF);
         wait_on(2, 1'b1, 6);
         wait_on(2, 1'b0, CAL_CYCLES + 5);
         chk("cal_len", 32'(CAL_CYCLES), 32'(n));
         wb(1'b0, ADDR_STAT, 4'hF, 32'h0); chk("done", 32'h1, (rdat >> 4) & 32'h1);
         wb(1'b1, ADDR_CTRL, 4'hF, 32'hF);
         repeat (3) @(posedge ref_clk);
         chk("no_retrig", 32'h0, 32'(busy));
         $display("test pass %0d done", p);
      end
      good <= 1'b0;
      wait_on(3, 1'b0, 8);
      $display("test supply done");
      report_and_stop;
   end
endmodule : tb
`default_nettype wire
